/* File: logic/ppdb_regs.sv */
// Function
// - the write and read address registers only steer the pins while dual-buffer mode is on.
// - write chip select 1 bit set drives chip select 1 on writes, cleared frees the pin as address line 14.
// - read chip select 1 bit set drives chip select 1 on reads, cleared selects address line 14.
// - the read input register holds a 16-bit field in bits 15:0 captured from port reads.
// - in dual-buffer mode read data is delivered only through the read input register.
// - outside dual-buffer mode read data goes to the ordinary data input register.
// - unimplemented bits of these registers read as zero.
// - every implemented field is software read/write and resets to zero.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "ppdb_params.svh"
`default_nettype none
module ppdb_regs (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [`PPDB_ADDR_W-1:0] reg_addr_i,
    input wire ppdb_pkg::ppdb_word_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output ppdb_pkg::ppdb_word_t reg_rdata_o,
    input wire logic dual_buffer_enable_i,
    input wire logic cyc_wr_i,
    input wire logic cyc_rd_i,
    input wire ppdb_pkg::ppdb_addr_t ctl_addr_i,
    input wire logic ctl_cs1_i,
    input wire ppdb_pkg::ppdb_data_t pin_data_i,
    output ppdb_pkg::ppdb_addr_t pin_addr_o,
    output logic pin_cs1_o,
    output logic address_line_fourteen_o,
    output ppdb_pkg::ppdb_data_t port_data_input_reg_o,
    output logic rd_done_o
);
    import ppdb_pkg::*;

    // ************************************************
    // reset release
    // ************************************************
    logic rst_s1_r, rst_b_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_r <= rst_s1_r;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    ppdb_addr_t write_address_field_r, read_address_field_r;
    logic write_chip_select_one_r, read_chip_select_one_r;
    ppdb_data_t rdin_r, din_r;
    ppdb_word_t reg_rdata_r;
    ppdb_cyc_t cyc_st_r;

    function automatic logic hit(input logic [`PPDB_ADDR_W-1:0] a,
        input logic [`PPDB_ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            write_address_field_r <= `PPDB_ZERO11;
            write_chip_select_one_r <= 1'b0;
            read_address_field_r <= `PPDB_ZERO11;
            read_chip_select_one_r <= 1'b0;
        end else if (reg_wr_i) begin
            if (hit(reg_addr_i, `PPDB_OFF_WRITE_ADDRESS_FIELD)) begin
                write_address_field_r <= reg_wdata_i[`PPDB_ADDR_MSB:0];
                write_chip_select_one_r <= reg_wdata_i[`PPDB_CS1_BIT];
            end
            if (hit(reg_addr_i, `PPDB_OFF_READ_ADDRESS_FIELD)) begin
                read_address_field_r <= reg_wdata_i[`PPDB_ADDR_MSB:0];
                read_chip_select_one_r <= reg_wdata_i[`PPDB_CS1_BIT];
            end
        end
    end

    // read data capture: hardware capture wins over a software write
    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            rdin_r <= `PPDB_ZERO16;
        end else if (cyc_rd_i && dual_buffer_enable_i) begin
            rdin_r <= pin_data_i;
        end else if (reg_wr_i && hit(reg_addr_i, `PPDB_OFF_RDIN)) begin
            rdin_r <= reg_wdata_i[`PPDB_DATA_MSB:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            din_r <= `PPDB_ZERO16;
        end else if (cyc_rd_i && !dual_buffer_enable_i) begin
            din_r <= pin_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            reg_rdata_r <= `PPDB_RESET_VAL;
        end else if (reg_rd_i) begin
            reg_rdata_r <= `PPDB_RESET_VAL;
            if (hit(reg_addr_i, `PPDB_OFF_WRITE_ADDRESS_FIELD)) begin
                reg_rdata_r[`PPDB_ADDR_MSB:0] <= write_address_field_r;
                reg_rdata_r[`PPDB_CS1_BIT] <= write_chip_select_one_r;
            end else if (hit(reg_addr_i, `PPDB_OFF_READ_ADDRESS_FIELD)) begin
                reg_rdata_r[`PPDB_ADDR_MSB:0] <= read_address_field_r;
                reg_rdata_r[`PPDB_CS1_BIT] <= read_chip_select_one_r;
            end else if (hit(reg_addr_i, `PPDB_OFF_RDIN)) begin
                reg_rdata_r[`PPDB_DATA_MSB:0] <= rdin_r;
            end
        end else begin
            reg_rdata_r <= `PPDB_RESET_VAL;
        end
    end
    assign reg_rdata_o = reg_rdata_r;
    assign port_data_input_reg_o = din_r;

    // ************************************************
    // pin drive
    // ************************************************
    ppdb_addr_t pin_addr_r;
    logic pin_cs1_r, a14_r, rd_done_r;
    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            cyc_st_r <= PPDB_IDLE;
            pin_addr_r <= `PPDB_ZERO11;
            pin_cs1_r <= 1'b0;
            a14_r <= 1'b0;
            rd_done_r <= 1'b0;
        end else begin
            rd_done_r <= cyc_rd_i;
            if (cyc_wr_i && dual_buffer_enable_i) begin
                cyc_st_r <= PPDB_WRITE;
                pin_addr_r <= write_address_field_r;
                pin_cs1_r <= write_chip_select_one_r;
                a14_r <= !write_chip_select_one_r;
            end else if (cyc_rd_i && dual_buffer_enable_i) begin
                cyc_st_r <= PPDB_READ;
                pin_addr_r <= read_address_field_r;
                pin_cs1_r <= read_chip_select_one_r;
                a14_r <= !read_chip_select_one_r;
            end else if (cyc_wr_i || cyc_rd_i) begin
                cyc_st_r <= cyc_wr_i ? PPDB_WRITE : PPDB_READ;
                pin_addr_r <= ctl_addr_i;
                pin_cs1_r <= ctl_cs1_i;
                a14_r <= !ctl_cs1_i;
            end else begin
                cyc_st_r <= PPDB_IDLE;
            end
        end
    end
    assign pin_addr_o = pin_addr_r;
    assign pin_cs1_o = pin_cs1_r;
    assign address_line_fourteen_o = a14_r;
    assign rd_done_o = rd_done_r;

    // ************************************************
    // checks
    // ************************************************
    wr_cs_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        cyc_wr_i && dual_buffer_enable_i |=> pin_cs1_o == $past(write_chip_select_one_r) && address_line_fourteen_o != pin_cs1_o)
        else $error("write chip select wrong");
    rd_cs_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        !cyc_wr_i && cyc_rd_i && dual_buffer_enable_i |=> pin_cs1_o == $past(read_chip_select_one_r))
        else $error("read chip select wrong");
    wr_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        cyc_wr_i && dual_buffer_enable_i |=> pin_addr_o == $past(write_address_field_r))
        else $error("write address wrong");
    plain_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        (cyc_wr_i || cyc_rd_i) && !dual_buffer_enable_i |=> pin_addr_o == $past(ctl_addr_i))
        else $error("address used outside dual mode");
    rdin_cap_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        cyc_rd_i && dual_buffer_enable_i |=> rdin_r == $past(pin_data_i))
        else $error("read input not captured");
    din_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        cyc_rd_i && dual_buffer_enable_i |=> $stable(din_r))
        else $error("data input touched in dual mode");
    rdin_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        cyc_rd_i && !dual_buffer_enable_i
        |=> din_r == $past(pin_data_i) && ($stable(rdin_r) || $past(reg_wr_i)))
        else $error("read input touched in plain mode");
    zero_hi_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        reg_rd_i |=> reg_rdata_o[`PPDB_WORD_MSB:`PPDB_DATA_MSB+1] == `PPDB_ZERO16)
        else $error("upper bits not zero");
    zero_mid_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        reg_rd_i && reg_addr_i != `PPDB_OFF_RDIN
        |=> !reg_rdata_o[`PPDB_DATA_MSB] && reg_rdata_o[`PPDB_CS1_BIT-1:`PPDB_ADDR_MSB+1] == '0)
        else $error("unused address bits not zero");
    wr_back_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        reg_wr_i && reg_addr_i == `PPDB_OFF_WRITE_ADDRESS_FIELD ##1 reg_rd_i && reg_addr_i == `PPDB_OFF_WRITE_ADDRESS_FIELD
        |=> reg_rdata_o[`PPDB_ADDR_MSB:0] == $past(reg_wdata_i[`PPDB_ADDR_MSB:0], 2))
        else $error("write address readback wrong");
    rdin_wr_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        reg_wr_i && reg_addr_i == `PPDB_OFF_RDIN && !(cyc_rd_i && dual_buffer_enable_i)
        |=> rdin_r == $past(reg_wdata_i[`PPDB_DATA_MSB:0]))
        else $error("read input write lost");
    rd_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        !cyc_wr_i && cyc_rd_i && dual_buffer_enable_i |=> pin_addr_o == $past(read_address_field_r))
        else $error("read address wrong");
    plain_cs_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        (cyc_wr_i || cyc_rd_i) && !dual_buffer_enable_i |=> pin_cs1_o == $past(ctl_cs1_i))
        else $error("chip select used outside dual mode");
    a14_excl_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        cyc_wr_i || cyc_rd_i |=> address_line_fourteen_o != pin_cs1_o)
        else $error("chip select and address line clash");
    pins_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        !cyc_wr_i && !cyc_rd_i |=> $stable(pin_addr_o) && $stable(pin_cs1_o))
        else $error("pins moved without a cycle");
    rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        !reg_rd_i |=> reg_rdata_o == `PPDB_RESET_VAL)
        else $error("read data not zero when idle");
    rd_done_a: assert property (@(posedge clk_i) disable iff (!rst_b_r)
        cyc_rd_i |=> rd_done_o)
        else $error("read done missing");

    // ************************************************
    // covers
    // ************************************************
    dual_wr_c: cover property (@(posedge clk_i) cyc_wr_i && dual_buffer_enable_i);
    dual_rd_c: cover property (@(posedge clk_i) cyc_rd_i && dual_buffer_enable_i);
    plain_rd_c: cover property (@(posedge clk_i) cyc_rd_i && !dual_buffer_enable_i);
    wr_rd_c: cover property (@(posedge clk_i) reg_wr_i ##1 reg_rd_i);
    wr_idle_c: cover property (@(posedge clk_i) cyc_st_r == PPDB_WRITE ##1 cyc_st_r == PPDB_IDLE);
endmodule
`default_nettype wire

/* File: inc/ppdb_params.svh */
`ifndef PPDB_PARAMS_SVH
`define PPDB_PARAMS_SVH
// register offsets (byte addresses on the plain port)
`define PPDB_ADDR_W 4
`define PPDB_OFF_CTRL 4'h0
`define PPDB_OFF_WRITE_ADDRESS_FIELD 4'h4
`define PPDB_OFF_READ_ADDRESS_FIELD 4'h8
`define PPDB_OFF_RDIN 4'hc
`define PPDB_OFF_DIN 4'h0
// field positions
`define PPDB_DUAL_BIT 17
`define PPDB_CS1_BIT 14
`define PPDB_ADDR_MSB 10
`define PPDB_DATA_MSB 15
`define PPDB_WORD_MSB 31
`define PPDB_RESET_VAL 32'h0000_0000
`define PPDB_ZERO16 16'h0000
`define PPDB_ZERO11 11'h000
`endif

/* File: inc/ppdb_pkg.sv */
package ppdb_pkg;
    typedef logic [31:0] ppdb_word_t;
    typedef logic [10:0] ppdb_addr_t;
    typedef logic [15:0] ppdb_data_t;
    typedef enum logic [1:0] {
        PPDB_IDLE = 2'b00,
        PPDB_WRITE = 2'b01,
        PPDB_READ = 2'b11
    } ppdb_cyc_t;
endpackage

/* File: testbench/ppdb_periph.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external peripheral: answers with a pattern of the pins it sees
// ****************************************
module ppdb_periph (
    input wire ppdb_pkg::ppdb_addr_t pin_addr_i,
    input wire logic pin_cs1_i,
    output ppdb_pkg::ppdb_data_t pin_data_o
);
    import ppdb_pkg::*;
    assign pin_data_o = {pin_cs1_i, 4'h0, pin_addr_i} ^ 16'h3c00;
endmodule
`default_nettype wire

/* File: testbench/test_parallel_port_dual_buffer_regs.sv */
`timescale 1ns/1ps
`include "ppdb_params.svh"
`default_nettype none
module test_parallel_port_dual_buffer_regs;
    import ppdb_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [`PPDB_ADDR_W-1:0] reg_addr_i = 4'h0;
    ppdb_word_t reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic dual_i = 1'b0;
    logic cyc_wr_i = 1'b0;
    logic cyc_rd_i = 1'b0;
    ppdb_addr_t ctl_addr_i = 11'h000;
    logic ctl_cs1_i = 1'b0;
    ppdb_word_t reg_rdata_o;
    ppdb_data_t pin_data_i;
    ppdb_addr_t pin_addr_o;
    logic pin_cs1_o;
    logic a14_o;
    ppdb_data_t din_o;
    logic rd_done_o;
    int fail_count = 0;
    int tests_run = 0;
    always #10 clk_i = ~clk_i;
    ppdb_regs dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .dual_buffer_enable_i(dual_i), .cyc_wr_i(cyc_wr_i),
        .cyc_rd_i(cyc_rd_i), .ctl_addr_i(ctl_addr_i), .ctl_cs1_i(ctl_cs1_i),
        .pin_data_i(pin_data_i), .pin_addr_o(pin_addr_o), .pin_cs1_o(pin_cs1_o),
        .address_line_fourteen_o(a14_o), .port_data_input_reg_o(din_o),
        .rd_done_o(rd_done_o));
    ppdb_periph periph_u (.pin_addr_i(pin_addr_o), .pin_cs1_i(pin_cs1_o),
        .pin_data_o(pin_data_i));
    // ****************************************
    // bus tasks and compare
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input ppdb_word_t d);
        @(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_i) reg_wr_i <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input ppdb_word_t exp);
        @(posedge clk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_i) reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    task cyc(input logic w, input logic dual);
        @(posedge clk_i) {dual_i, cyc_wr_i, cyc_rd_i} <= {dual, w, !w};
        @(posedge clk_i) {cyc_wr_i, cyc_rd_i} <= 2'b00;
        #1 chk(32'(rd_done_o), 32'(!w));
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        rd_chk(`PPDB_OFF_WRITE_ADDRESS_FIELD, 32'h0000_0000);
        rd_chk(`PPDB_OFF_READ_ADDRESS_FIELD, 32'h0000_0000);
        rd_chk(`PPDB_OFF_RDIN, 32'h0000_0000);
    endtask
    task t_fields;
        wr(`PPDB_OFF_WRITE_ADDRESS_FIELD, 32'hffff_ffff);
        wr(`PPDB_OFF_READ_ADDRESS_FIELD, 32'hffff_ffff);
        wr(`PPDB_OFF_RDIN, 32'hffff_ffff);
        wr(4'h2, 32'hffff_ffff);
        rd_chk(`PPDB_OFF_WRITE_ADDRESS_FIELD, 32'h0000_47ff);
        rd_chk(`PPDB_OFF_READ_ADDRESS_FIELD, 32'h0000_47ff);
        rd_chk(`PPDB_OFF_RDIN, 32'h0000_ffff);
        rd_chk(4'h2, 32'h0000_0000);
    endtask
    task t_plain;
        @(posedge clk_i) {ctl_addr_i, ctl_cs1_i} <= {11'h2aa, 1'b0};
        cyc(1'b1, 1'b0);
        chk(32'({pin_cs1_o, a14_o, pin_addr_o}), 32'h0000_0aaa);
        cyc(1'b0, 1'b0);
        chk(32'(din_o), 32'h0000_3eaa);
        rd_chk(`PPDB_OFF_RDIN, 32'h0000_ffff);
    endtask
    task t_dual_wr;
        wr(`PPDB_OFF_WRITE_ADDRESS_FIELD, 32'h0000_4123);
        cyc(1'b1, 1'b1);
        chk(32'({pin_cs1_o, a14_o, pin_addr_o}), 32'h0000_1123);
        wr(`PPDB_OFF_WRITE_ADDRESS_FIELD, 32'h0000_0055);
        cyc(1'b1, 1'b1);
        chk(32'({pin_cs1_o, a14_o, pin_addr_o}), 32'h0000_0855);
    endtask
    task t_dual_rd;
        wr(`PPDB_OFF_READ_ADDRESS_FIELD, 32'h0000_0007);
        cyc(1'b0, 1'b1);
        chk(32'({pin_cs1_o, a14_o, pin_addr_o}), 32'h0000_0807);
        wr(`PPDB_OFF_READ_ADDRESS_FIELD, 32'h0000_4321);
        cyc(1'b0, 1'b1);
        chk(32'({pin_cs1_o, a14_o, pin_addr_o}), 32'h0000_1321);
        cyc(1'b0, 1'b1);
        rd_chk(`PPDB_OFF_RDIN, 32'h0000_bf21);
        chk(32'(din_o), 32'h0000_3eaa);
    endtask
    task t_b2b;
        @(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {`PPDB_OFF_WRITE_ADDRESS_FIELD, 32'h0000_4abc, 1'b1};
        @(posedge clk_i) {reg_wr_i, reg_rd_i} <= 2'b01;
        @(posedge clk_i) reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, 32'h0000_42bc);
    endtask
    task t_reset_mid;
        @(posedge clk_i) rst_b_i <= 1'b0;
        @(posedge clk_i) rst_b_i <= 1'b1;
        #1 chk(32'({din_o, pin_addr_o, pin_cs1_o, a14_o}), 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        t_reset();
    endtask
    task print_verdict;
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_fields();
        t_plain();
        t_dual_wr();
        t_dual_rd();
        t_b2b();
        t_reset_mid();
        print_verdict();
    end
endmodule
`default_nettype wire
